// ===== verilog/seg_exec_map.vh
// opcode, register index, reset value and trap vector constants for the segment/misc executor
`ifndef SEG_EXEC_MAP_VH
`define SEG_EXEC_MAP_VH
// operation codes on op_code
`define OP_IDLE          5'h00
`define OP_SEG_FROM_GPR  5'h01
`define OP_SEG_FROM_MEM  5'h02
`define OP_SEG_TO_GPR    5'h03
`define OP_SEG_TO_MEM    5'h04
`define OP_SEG_PUSH      5'h05
`define OP_SEG_POP       5'h06
`define OP_FAR_JUMP      5'h07
`define OP_FAR_INVOKE    5'h08
`define OP_FAR_EXIT      5'h09
`define OP_NEAR_JUMP     5'h0A
`define OP_SOFT_TRAP     5'h0B
`define OP_OVF_TRAP      5'h0C
`define OP_RANGE_TRAP    5'h0D
`define OP_HANDLER_EXIT  5'h0E
`define OP_LOAD_PTR      5'h0F
`define OP_ADDR_COMPUTE  5'h10
`define OP_TABLE_LOOKUP  5'h11
`define OP_PROC_IDENT    5'h12
`define OP_RESERVED_BAD  5'h13
// segment register index on seg_sel
`define SEG_EXTRA        3'h0
`define SEG_CODE         3'h1
`define SEG_STACK        3'h2
`define SEG_DATA         3'h3
`define SEG_THIRD        3'h4
`define SEG_FOURTH       3'h5
// general register index of table_base_reg, the accumulator and the stack pointer
`define GPR_ACC          3'h0
`define GPR_TABLE_BASE   3'h3
`define GPR_STACK_PTR    3'h4
// reset values
`define RST_SEL          16'h0000
`define RST_IP           32'h00000000
`define RST_SP           32'h0000FFFC
// trap vectors and processor ident value
`define VEC_INVALID_OP   8'h06
`define VEC_OVERFLOW     8'h04
`define VEC_RANGE        8'h05
`define IDENT_VALUE      32'h00000000
`endif

// ===== verilog/addr_gen.v
// effective address generator: base + index * scale + displacement

module addr_gen (
	// operand fields
	input  wire        base_en,
	input  wire [31:0] base_val,
	input  wire        index_en,
	input  wire [31:0] index_val,
	input  wire [1:0]  scale_log2,
	input  wire [31:0] disp,
	// result
	output wire [31:0] eff_addr
);

	wire [31:0] base_term;
	wire [31:0] index_term;

	assign base_term  = base_en ? base_val : 32'h00000000;
	assign index_term = index_en ? (index_val << scale_log2) : 32'h00000000;
	// wraps modulo 2^32 like the in-segment offset
	assign eff_addr   = base_term + index_term + disp;

endmodule // addr_gen

// ===== verilog/seg_misc_exec.v
// executor for segment register and miscellaneous instructions
`include "seg_exec_map.vh"

module seg_misc_exec #(
	parameter IDENT_INFO = `IDENT_VALUE // arbitrary value
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// instruction
	input  wire        op_valid,
	output wire        op_ready,
	input  wire [4:0]  op_code,
	input  wire [2:0]  seg_sel,
	input  wire [2:0]  gpr_sel,
	input  wire [31:0] op_len,
	input  wire [31:0] imm_offset,
	input  wire [15:0] imm_selector,
	input  wire        base_en,
	input  wire [2:0]  base_sel,
	input  wire        index_en,
	input  wire [2:0]  index_sel,
	input  wire [1:0]  scale_log2,
	input  wire [31:0] disp,
	input  wire [7:0]  trap_vector,
	input  wire        ovf_flag,
	input  wire [31:0] bound_lo,
	input  wire [31:0] bound_hi,
	// data memory
	output reg         mem_req,
	output reg         mem_we,
	output reg  [31:0] mem_addr,
	output reg  [31:0] mem_wdata,
	output reg  [1:0]  mem_size,
	input  wire        mem_ack,
	input  wire [31:0] mem_rdata,
	// architectural state and events
	output reg  [31:0] instr_pointer,
	output reg  [15:0] code_segment_reg,
	output reg  [15:0] data_segment_reg,
	output reg  [15:0] extra_segment_reg,
	output reg  [15:0] third_data_seg_reg,
	output reg  [15:0] fourth_data_seg_reg,
	output reg  [15:0] stack_segment_reg,
	output reg         invalid_op_exc,
	output reg         done
);

	localparam ST_IDLE  = 4'b0001;
	localparam ST_MEM   = 4'b0010;
	localparam ST_MEM2  = 4'b0100;
	localparam ST_MEM3  = 4'b1000;

	reg [3:0]  state;
	reg [31:0] gpr [0:7];
	reg [4:0]  cur_op;
	reg [2:0]  cur_seg;
	reg [2:0]  cur_gpr;
	reg [31:0] tmp;
	reg [31:0] resume_ip;
	reg [15:0] tgt_sel;
	reg [31:0] tgt_ip;
	reg [15:0] seg_val;
	reg        seg_bad;
	integer    i;

	wire [31:0] eff_addr;
	wire [31:0] sp = gpr[`GPR_STACK_PTR];
	wire [31:0] next_ip = instr_pointer + op_len;
	wire        range_bad = (gpr[gpr_sel] < bound_lo) ||
	                        (gpr[gpr_sel] > bound_hi);

	assign op_ready = (state == ST_IDLE);

	addr_gen u_addr (
		.base_en    (base_en),
		.base_val   (gpr[base_sel]),
		.index_en   (index_en),
		.index_val  (gpr[index_sel]),
		.scale_log2 (scale_log2),
		.disp       (disp),
		.eff_addr   (eff_addr)
	);

	////////////////////////////////////////////////////////////////////////
	// selector source mux; code segment is readable, written only by far transfers and exits
	always @* begin
		seg_bad = 1'b0;
		case (seg_sel)
		`SEG_EXTRA:  seg_val = extra_segment_reg;
		`SEG_CODE:   seg_val = code_segment_reg;
		`SEG_STACK:  seg_val = stack_segment_reg;
		`SEG_DATA:   seg_val = data_segment_reg;
		`SEG_THIRD:  seg_val = third_data_seg_reg;
		`SEG_FOURTH: seg_val = fourth_data_seg_reg;
		default: begin
			seg_val = `RST_SEL;
			seg_bad = 1'b1;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// writes selector into a data or stack segment; code segment excluded by design
	task write_seg;
		input [2:0]  idx;
		input [15:0] val;
		begin
			case (idx)
			`SEG_EXTRA:  extra_segment_reg   <= val;
			`SEG_STACK:  stack_segment_reg   <= val;
			`SEG_DATA:   data_segment_reg    <= val;
			`SEG_THIRD:  third_data_seg_reg  <= val;
			`SEG_FOURTH: fourth_data_seg_reg <= val;
			default: ;
			endcase
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state               <= ST_IDLE;
			for (i = 0; i < 8; i = i + 1)
				gpr[i] <= 32'h00000000;
			instr_pointer       <= `RST_IP;
			code_segment_reg    <= `RST_SEL;
			data_segment_reg    <= `RST_SEL;
			extra_segment_reg   <= `RST_SEL;
			third_data_seg_reg  <= `RST_SEL;
			fourth_data_seg_reg <= `RST_SEL;
			stack_segment_reg   <= `RST_SEL;
			mem_req             <= 1'b0;
			mem_we              <= 1'b0;
			mem_addr            <= 32'h00000000;
			mem_wdata           <= 32'h00000000;
			mem_size            <= 2'h0;
			invalid_op_exc      <= 1'b0;
			done                <= 1'b0;
			cur_op              <= `OP_IDLE;
			cur_seg             <= 3'h0;
			cur_gpr             <= 3'h0;
			tmp                 <= 32'h00000000;
			resume_ip           <= 32'h00000000;
			tgt_sel             <= `RST_SEL;
			tgt_ip              <= 32'h00000000;
		end else begin
			done           <= 1'b0;
			invalid_op_exc <= 1'b0;
			if (state == ST_IDLE && op_valid) begin
				gpr[`GPR_STACK_PTR] <= sp; // stack stays unless changed below
				cur_op  <= op_code;
				cur_seg <= seg_sel;
				cur_gpr <= gpr_sel;
				resume_ip <= next_ip;
				case (op_code)
				`OP_IDLE: begin
					instr_pointer <= next_ip;
					done          <= 1'b1;
				end
				`OP_SEG_FROM_GPR, `OP_SEG_POP, `OP_SEG_FROM_MEM: begin
					if (seg_sel == `SEG_CODE || seg_bad) begin
						invalid_op_exc <= 1'b1;
						done           <= 1'b1;
					end else if (op_code == `OP_SEG_FROM_GPR) begin
						write_seg(seg_sel, gpr[gpr_sel][15:0]);
						instr_pointer <= next_ip;
						done          <= 1'b1;
					end else begin
						mem_req  <= 1'b1;
						mem_we   <= 1'b0;
						mem_size <= 2'h1;
						mem_addr <= (op_code == `OP_SEG_POP) ? sp : eff_addr;
						state    <= ST_MEM;
					end
				end
				`OP_SEG_TO_GPR: begin
					gpr[gpr_sel]  <= {16'h0000, seg_val};
					instr_pointer <= next_ip;
					done          <= 1'b1;
				end
				`OP_SEG_TO_MEM, `OP_SEG_PUSH: begin
					mem_req   <= 1'b1;
					mem_we    <= 1'b1;
					mem_size  <= 2'h1;
					mem_wdata <= {16'h0000, seg_val};
					mem_addr  <= (op_code == `OP_SEG_PUSH) ?
					             sp - 32'h00000004 : eff_addr;
					if (op_code == `OP_SEG_PUSH)
						gpr[`GPR_STACK_PTR] <= sp - 32'h00000004;
					state     <= ST_MEM;
				end
				`OP_FAR_JUMP: begin
					code_segment_reg <= imm_selector;
					instr_pointer    <= imm_offset;
					done             <= 1'b1;
				end
				`OP_NEAR_JUMP: begin
					instr_pointer <= imm_offset;
					done          <= 1'b1;
				end
				`OP_FAR_INVOKE, `OP_SOFT_TRAP, `OP_OVF_TRAP,
				`OP_RANGE_TRAP: begin
					tgt_sel <= imm_selector;
					tgt_ip  <= imm_offset;
					if ((op_code == `OP_OVF_TRAP && !ovf_flag) ||
					    (op_code == `OP_RANGE_TRAP && !range_bad)) begin
						instr_pointer <= next_ip; // no trap taken
						done          <= 1'b1;
					end else begin
						// push cs first, then return ip
						mem_req   <= 1'b1;
						mem_we    <= 1'b1;
						mem_size  <= 2'h2;
						mem_addr  <= sp - 32'h00000004;
						mem_wdata <= {16'h0000, code_segment_reg};
						gpr[`GPR_STACK_PTR] <= sp - 32'h00000004;
						state     <= ST_MEM;
					end
				end
				`OP_FAR_EXIT, `OP_HANDLER_EXIT: begin
					mem_req  <= 1'b1;
					mem_we   <= 1'b0;
					mem_size <= 2'h2;
					mem_addr <= sp;
					state    <= ST_MEM;
				end
				`OP_LOAD_PTR: begin
					if (seg_sel == `SEG_CODE || seg_bad) begin
						invalid_op_exc <= 1'b1;
						done           <= 1'b1;
					end else begin
						mem_req  <= 1'b1;
						mem_we   <= 1'b0;
						mem_size <= 2'h2;
						mem_addr <= eff_addr;
						tmp      <= eff_addr;
						state    <= ST_MEM;
					end
				end
				`OP_ADDR_COMPUTE: begin
					gpr[gpr_sel]  <= eff_addr;
					instr_pointer <= next_ip;
					done          <= 1'b1;
				end
				`OP_TABLE_LOOKUP: begin
					mem_req  <= 1'b1;
					mem_we   <= 1'b0;
					mem_size <= 2'h0;
					mem_addr <= gpr[`GPR_TABLE_BASE] +
					            {24'h000000, gpr[`GPR_ACC][7:0]};
					state    <= ST_MEM;
				end
				`OP_PROC_IDENT: begin
					gpr[`GPR_ACC] <= IDENT_INFO;
					instr_pointer <= next_ip;
					done          <= 1'b1;
				end
				default: begin
					// covers reserved_bad_op and every unknown code
					invalid_op_exc <= 1'b1;
					done           <= 1'b1;
				end
				endcase
			end else if (state != ST_IDLE && mem_ack) begin
				mem_req <= 1'b0;
				case (state)
				ST_MEM: begin
					case (cur_op)
					`OP_SEG_FROM_MEM, `OP_SEG_POP: begin
						write_seg(cur_seg, mem_rdata[15:0]);
						if (cur_op == `OP_SEG_POP)
							gpr[`GPR_STACK_PTR] <= sp + 32'h00000004;
						instr_pointer <= resume_ip;
						done          <= 1'b1;
						state         <= ST_IDLE;
					end
					`OP_TABLE_LOOKUP: begin
						gpr[`GPR_ACC] <= {gpr[`GPR_ACC][31:8],
						                  mem_rdata[7:0]};
						instr_pointer <= resume_ip;
						done          <= 1'b1;
						state         <= ST_IDLE;
					end
					`OP_LOAD_PTR: begin
						gpr[cur_gpr] <= mem_rdata;
						mem_req      <= 1'b1;
						mem_size     <= 2'h1;
						mem_addr     <= tmp + 32'h00000004;
						state        <= ST_MEM2;
					end
					`OP_FAR_EXIT, `OP_HANDLER_EXIT: begin
						tgt_ip   <= mem_rdata;
						gpr[`GPR_STACK_PTR] <= sp + 32'h00000004;
						mem_req  <= 1'b1;
						mem_addr <= sp + 32'h00000004;
						state    <= ST_MEM2;
					end
					`OP_FAR_INVOKE, `OP_SOFT_TRAP, `OP_OVF_TRAP,
					`OP_RANGE_TRAP: begin
						mem_req   <= 1'b1;
						mem_addr  <= sp - 32'h00000004;
						mem_wdata <= resume_ip;
						gpr[`GPR_STACK_PTR] <= sp - 32'h00000004;
						state     <= ST_MEM2;
					end
					default: begin
						instr_pointer <= resume_ip;
						done          <= 1'b1;
						state         <= ST_IDLE;
					end
					endcase
				end
				ST_MEM2: begin
					case (cur_op)
					`OP_LOAD_PTR: write_seg(cur_seg, mem_rdata[15:0]);
					`OP_FAR_EXIT, `OP_HANDLER_EXIT: begin
						code_segment_reg <= mem_rdata[15:0];
						gpr[`GPR_STACK_PTR] <= sp + 32'h00000004;
					end
					default: code_segment_reg <= tgt_sel;
					endcase
					if (cur_op == `OP_LOAD_PTR)
						instr_pointer <= resume_ip;
					else
						instr_pointer <= tgt_ip;
					done  <= 1'b1;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end

endmodule // seg_misc_exec

// ===== tb/seg_exec_chk.sv
// port assertions for the segment and miscellaneous executor
`include "seg_exec_map.vh"
module seg_exec_chk (
	// clock and reset
	input wire        clk,
	input wire        rst_n,
	// instruction
	input wire        op_valid,
	input wire        op_ready,
	input wire [4:0]  op_code,
	input wire [2:0]  seg_sel,
	input wire [31:0] op_len,
	input wire [31:0] imm_offset,
	input wire [15:0] imm_selector,
	// memory and state
	input wire        mem_req,
	input wire        mem_we,
	input wire [31:0] mem_wdata,
	input wire [1:0]  mem_size,
	input wire [31:0] instr_pointer,
	input wire [15:0] code_segment_reg,
	input wire        invalid_op_exc,
	input wire        done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	reg  [4:0] last_op;
	wire       go = op_valid && op_ready;
	wire [4:0] oc = op_code;
	////////////////
	// kept so a late code segment change is tied to its opcode
	always @(posedge clk or negedge rst_n)
		if (!rst_n)
			last_op <= 5'h00;
		else if (go)
			last_op <= oc;
	////////////////
	a_idle_ip_step:
		assert property (go && oc == `OP_IDLE |=> done &&
			instr_pointer == $past(instr_pointer) + $past(op_len))
		else $error("idle ip step wrong");
	a_idle_cs_keep:
		assert property (go && oc == `OP_IDLE |=> !mem_req &&
			$stable(code_segment_reg) ##1 (!done || $past(go)))
		else $error("idle touched state");
	a_bad_op_exc:
		assert property (go && oc == `OP_RESERVED_BAD |=> invalid_op_exc &&
			done && $stable(instr_pointer))
		else $error("no invalid opcode pulse");
	a_code_load_exc:
		assert property (go && oc inside {5'h01, 5'h02, 5'h06, 5'h0F} &&
			seg_sel == `SEG_CODE |=> invalid_op_exc &&
			$stable(code_segment_reg))
		else $error("code segment load accepted");
	a_cs_far_only:
		assert property ($changed(code_segment_reg) |->
			last_op inside {[5'h07:5'h09], [5'h0B:5'h0E]})
		else $error("code segment changed by near op");
	a_jump_target:
		assert property (go && oc == `OP_FAR_JUMP |=>
			code_segment_reg == $past(imm_selector) &&
			instr_pointer == $past(imm_offset))
		else $error("far jump target wrong");
	a_invoke_cs_first:
		assert property (go && oc == `OP_FAR_INVOKE |=> mem_req && mem_we &&
			mem_wdata[15:0] == $past(code_segment_reg))
		else $error("invoke did not push code segment first");
	a_exit_pop_first:
		assert property (go && oc == `OP_FAR_EXIT |=> mem_req && !mem_we)
		else $error("far exit did not pop");
	a_lookup_byte:
		assert property (go && oc == `OP_TABLE_LOOKUP |=> mem_req &&
			!mem_we && mem_size == 2'h0)
		else $error("lookup not a byte read");
	a_compute_no_mem:
		assert property (go && oc == `OP_ADDR_COMPUTE |=> !mem_req && done)
		else $error("address compute touched memory");
	cover property (go && oc == `OP_FAR_INVOKE);
	cover property (go && oc == `OP_TABLE_LOOKUP);
	cover property (invalid_op_exc);
endmodule // seg_exec_chk

bind seg_misc_exec seg_exec_chk chk_u (.*);

// ===== tb/mem_model.sv
// data memory and stack partner with random wait states
module mem_model (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// request and answer
	input  wire        mem_req,
	input  wire [31:0] mem_addr,
	output logic       mem_ack,
	output logic [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	int wait_cnt;
	// data is an address pattern, so writes need no storage
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
			wait_cnt <= 0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata; // no stale data outside an answer
			if (mem_req && !mem_ack) begin
				if (wait_cnt == 0) begin
					mem_ack <= 1'b1;
					mem_rdata <= {mem_addr[15:0], ~mem_addr[15:0]};
					wait_cnt <= $urandom % 3;
				end else
					wait_cnt <= wait_cnt - 1;
			end
		end
	end
endmodule // mem_model

// ===== tb/testbench.sv
// self-checking bench for the segment and miscellaneous executor
`include "seg_exec_map.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, op_valid, base_en, index_en, ovf_flag, mem_ack;
	logic [4:0]  op_code;
	logic [2:0]  seg_sel, gpr_sel, base_sel, index_sel;
	logic [1:0]  scale_log2;
	logic [31:0] op_len, imm_offset, disp, bound_lo, bound_hi, mem_rdata;
	logic [15:0] imm_selector;
	logic [7:0]  trap_vector;
	wire         op_ready, mem_req, mem_we, invalid_op_exc, done;
	wire  [1:0]  mem_size;
	wire  [31:0] mem_addr, mem_wdata, instr_pointer;
	wire  [15:0] code_segment_reg, data_segment_reg, extra_segment_reg;
	wire  [15:0] third_data_seg_reg, fourth_data_seg_reg, stack_segment_reg;
	int          err_total, num_checks, i, t;
	logic [31:0] gp[8], ip, ea, rq[$];
	logic [15:0] sg[8];
	logic [63:0] wq[$];
	logic        bad, hit;
	seg_misc_exec dut_u (.*);
	mem_model mem_u (.*);
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
		if (mem_req && mem_ack)
			if (mem_we) wq.push_back({mem_addr, mem_wdata});
			else rq.push_back(mem_addr);
	////////////////
	task automatic chk(input logic [127:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// an empty queue pops x, so a missing access cannot match
	task automatic chk_mem(input logic [31:0] a, d, m, input bit we);
		logic [63:0] w;
		w = we ? wq.pop_front() : {rq.pop_front(), 32'h0};
		chk({w[63:32], w[31:0] & m}, {a, d & m});
	endtask
	task automatic ld(input logic [31:0] a, output logic [31:0] d);
		chk_mem(a, 0, 0, 0);
		d = {a[15:0], ~a[15:0]};
	endtask
	task automatic push(input logic [31:0] d, m);
		gp[4] -= 4;
		chk_mem(gp[4], d, m, 1);
	endtask
	task automatic pop(output logic [31:0] d);
		ld(gp[4], d);
		gp[4] += 4;
	endtask
	////////////////
	task automatic model;
		logic [31:0] d, q;
		ea = (base_en ? gp[base_sel] : 0) + disp +
			(index_en ? gp[index_sel] << scale_log2 : 0);
		// stores from a missing segment index read as zero, not refused
		bad = op_code > 5'h13 || op_code == 5'h13 ||
			(op_code inside {5'h01, 5'h02, 5'h06, 5'h0F} &&
			(seg_sel == 3'h1 || seg_sel > 3'h5));
		hit = op_code == 5'h08 || op_code == 5'h0B ||
			(op_code == 5'h0C && ovf_flag) || (op_code == 5'h0D &&
			(gp[gpr_sel] < bound_lo || gp[gpr_sel] > bound_hi));
		chk({done, invalid_op_exc}, {1'b1, bad});
		if (!bad) begin
			ip += op_len;
			if (hit) begin
				push(sg[1], 32'hFFFF);
				push(ip, 32'hFFFFFFFF);
				{sg[1], ip} = {imm_selector, imm_offset};
			end
			case (op_code)
			5'h01: sg[seg_sel] = gp[gpr_sel][15:0];
			5'h02: begin ld(ea, d); sg[seg_sel] = d[15:0]; end
			5'h03: gp[gpr_sel] = {16'h0, sg[seg_sel]};
			5'h04: chk_mem(ea, sg[seg_sel], 32'hFFFF, 1);
			5'h05: push(sg[seg_sel], 32'hFFFF);
			5'h06: begin pop(d); sg[seg_sel] = d[15:0]; end
			5'h07: {sg[1], ip} = {imm_selector, imm_offset};
			5'h0A: ip = imm_offset;
			5'h09, 5'h0E: begin pop(ip); pop(d); sg[1] = d[15:0]; end
			5'h0F: begin ld(ea, d); ld(ea + 4, q); gp[gpr_sel] = d;
				sg[seg_sel] = q[15:0]; end
			5'h10: gp[gpr_sel] = ea;
			5'h11: begin ld(gp[3] + gp[0][7:0], d); gp[0][7:0] = d[7:0]; end
			5'h12: gp[0] = `IDENT_VALUE;
			default: ;
			endcase
		end
		chk({ip, sg[1], sg[3], sg[0], sg[4], sg[5], sg[2]},
			{instr_pointer, code_segment_reg, data_segment_reg,
			extra_segment_reg, third_data_seg_reg, fourth_data_seg_reg,
			stack_segment_reg});
		chk(rq.size() + wq.size(), 0);
	endtask
	task automatic run(input int t);
		int n, c;
		c = $urandom % 24;
		@(posedge clk);
		op_code <= 5'(c);
		{seg_sel, gpr_sel, base_sel, index_sel} <= 12'($urandom);
		{scale_log2, trap_vector} <= 10'($urandom);
		{base_en, index_en, ovf_flag} <= t ? 3'($urandom) : 3'h0;
		{imm_selector, op_len} <= {16'($urandom), 32'($urandom % 15 + 1)};
		{imm_offset, disp, bound_lo, bound_hi} <= {4{$urandom}};
		op_valid <= 1;
		n = 0;
		do @(posedge clk); while (op_ready !== 1 && ++n < 60);
		op_valid <= 0;
		n = 0;
		do @(negedge clk); while (done !== 1 && ++n < 60);
		model;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////
	initial begin
		{rst_n, op_valid, op_code, seg_sel, gpr_sel, base_en, base_sel} = '0;
		{index_en, index_sel, scale_log2, op_len, imm_offset} = '0;
		{imm_selector, disp, trap_vector, ovf_flag, bound_lo, bound_hi} = '0;
		ip = 0;
		foreach (gp[i]) {gp[i], sg[i]} = '0;
		void'($urandom(32'h8F75));
		repeat (8) @(posedge clk);
		rst_n <= 1;
		for (t = 0; t < 2; t++) begin
			for (i = 0; i < 150; i++) run(t);
			$display("test %0d done, checks %0d", t, num_checks);
		end
		end_sim;
	end
	// whole run is near 1200 cycles, so this only cuts a hang
	initial begin
		#100us;
		err_total++;
		end_sim;
	end
endmodule // testbench
